// file: dpmb_consts.vh
// constants for the dual-port mailbox with parity
`ifndef DPMB_CONSTS_VH
`define DPMB_CONSTS_VH

// ****************************************
// word and byte layout
// ****************************************
`define DPMB_WORD_W 36
`define DPMB_BYTE_W 9
`define DPMB_NBYTES 4
`define DPMB_LOW_W 8
`define DPMB_PAR_BIT 8

// ****************************************
// data fifo shape
// ****************************************
`define DPMB_FIFO_DEPTH 16
`define DPMB_FIFO_AW 4

// ****************************************
// reset values
// ****************************************
`define DPMB_FLAG_RST 1'b1
`define DPMB_OE_N_RST 1'b1
`define DPMB_PERR_N_RST 1'b1
`define DPMB_WORD_RST 36'h000000000

// ****************************************
// synchroniser vector layout
// ****************************************
`define DPMB_PORT_CTL_W 5
`define DPMB_PORT_IN_W 41
`define DPMB_SYNC_W 83
// both chip-select bits (81 and 40) reset high so neither port looks selected
`define DPMB_SYNC_RST 83'h200000000010000000000

`endif

// file: dpmb_mailbox.v
// dual-port mailbox registers, parity check and generation, and the port a to b data fifo
`timescale 1ns/1ns
`default_nettype none
`include "dpmb_consts.vh"


// ****************************************
// data fifo
// ****************************************
module dpmb_fifo #(
	parameter WIDTH = `DPMB_WORD_W,
	parameter DEPTH = `DPMB_FIFO_DEPTH,
	parameter AW = `DPMB_FIFO_AW
) (
	input wire ref_clk, // system clock
	input wire resetn, // synchronous reset, active low
	input wire in_valid, // word offered
	output wire in_ready, // room for a word
	input wire [WIDTH-1:0] in_data, // word to store
	output wire out_valid, // a word is held
	input wire out_ready, // drain takes the head word
	output wire [WIDTH-1:0] out_data // head word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	// honest full and empty from the word count; the count has one spare bit,
	// so a full buffer and an empty one never look alike
	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_q];

	// storage write, no reset needed for the array
	always @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// pointers wrap naturally at a power-of-two depth
	// (the depth must stay a power of two for that to hold)
	always @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			case ({push, pop})
				2'b10: count_q <= count_q + {{AW{1'b0}}, 1'b1};
				2'b01: count_q <= count_q - {{AW{1'b0}}, 1'b1};
				default: count_q <= count_q;
			endcase
		end
	end
endmodule

// ****************************************
// mailbox top
// ****************************************
module dpmb_mailbox (
	input wire ref_clk, // system clock, 25 MHz
	input wire resetn, // synchronous reset, active low
	input wire port_a_select_n, // port a chip select, active low
	input wire port_a_write_not_read, // port a high write, low read
	input wire port_a_enable, // port a transfer enable
	input wire port_a_mail_select, // port a mail register instead of fifo
	input wire port_a_parity_generate, // port a parity generation on reads
	input wire [`DPMB_WORD_W-1:0] port_a_bus_in, // port a bus level
	output reg [`DPMB_WORD_W-1:0] port_a_bus_out_q, // port a bus drive value
	output reg port_a_bus_oe_n_q, // port a bus enable, low while driving
	output reg port_a_parity_error_n_q, // port a parity error, active low
	output wire port_a_fifo_ready, // fifo has room for a port a write
	input wire port_b_select_n, // port b chip select, active low
	input wire port_b_write_not_read, // port b high write, low read
	input wire port_b_enable, // port b transfer enable
	input wire port_b_mail_select, // port b mail register instead of fifo
	input wire port_b_parity_generate, // port b parity generation on reads
	input wire [`DPMB_WORD_W-1:0] port_b_bus_in, // port b bus level
	output reg [`DPMB_WORD_W-1:0] port_b_bus_out_q, // port b bus drive value
	output reg port_b_bus_oe_n_q, // port b bus enable, low while driving
	output reg port_b_parity_error_n_q, // port b parity error, active low
	output wire port_b_fifo_valid, // fifo holds a word for port b
	input wire odd_even_select, // high odd parity, low even parity
	output reg mail_ab_empty_flag, // a-to-b mail free when high
	output reg mail_ba_empty_flag // b-to-a mail free when high
);

	// ****************************************
	// parity functions
	// ****************************************

	// high when any byte fails; a 9-bit byte with odd ones has even zeros
	// so counting ones instead of zeros keeps each tree a plain xor
	function byte_parity_fail;
		input [`DPMB_WORD_W-1:0] word;
		input odd;
		integer i;
		reg fail;
		begin
			fail = 1'b0;
			for (i = 0; i < `DPMB_NBYTES; i = i + 1) begin
				fail = fail | ((^word[i*`DPMB_BYTE_W +: `DPMB_BYTE_W]) ^ odd);
			end
			byte_parity_fail = fail;
		end
	endfunction

	// replace each byte msb with parity over its lower eight bits
	// the word passed in is left as it is; only the copy is altered
	function [`DPMB_WORD_W-1:0] parity_insert;
		input [`DPMB_WORD_W-1:0] word;
		input odd;
		integer i;
		reg [`DPMB_WORD_W-1:0] w;
		begin
			w = word;
			for (i = 0; i < `DPMB_NBYTES; i = i + 1) begin
				w[i*`DPMB_BYTE_W + `DPMB_PAR_BIT] =
					(^word[i*`DPMB_BYTE_W +: `DPMB_LOW_W]) ^ odd;
			end
			parity_insert = w;
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	wire [`DPMB_SYNC_W-1:0] pins_raw;
	reg [`DPMB_SYNC_W-1:0] pins_meta_q;
	reg [`DPMB_SYNC_W-1:0] pins_sync_q;

	assign pins_raw = {odd_even_select,
		port_b_select_n, port_b_write_not_read, port_b_enable,
		port_b_mail_select, port_b_parity_generate, port_b_bus_in,
		port_a_select_n, port_a_write_not_read, port_a_enable,
		port_a_mail_select, port_a_parity_generate, port_a_bus_in};

	// two flops on every pin before any logic looks at it; the reset value
	// holds both chip selects high, so neither bus is driven and no port
	// acts while the pipeline refills after reset
	always @(posedge ref_clk) begin
		if (!resetn) begin
			pins_meta_q <= `DPMB_SYNC_RST;
			pins_sync_q <= `DPMB_SYNC_RST;
		end else begin
			pins_meta_q <= pins_raw;
			pins_sync_q <= pins_meta_q;
		end
	end

	// ****************************************
	// decoded port controls
	// ****************************************
	wire [`DPMB_WORD_W-1:0] a_bus;
	wire [`DPMB_WORD_W-1:0] b_bus;
	wire a_cs_n;
	wire a_wnr;
	wire a_en;
	wire a_mb;
	wire a_pg;
	wire b_cs_n;
	wire b_wnr;
	wire b_en;
	wire b_mb;
	wire b_pg;
	wire odd_sel;
	wire a_read_out;
	wire b_read_out;
	wire a_mail_wr;
	wire a_mail_rd;
	wire a_fifo_wr;
	wire b_mail_wr;
	wire b_mail_rd;
	wire b_fifo_rd;
	wire a_mail_gen;
	wire b_mail_gen;

	// unpack the synchronised pins in the order they were packed
	assign a_bus = pins_sync_q[`DPMB_WORD_W-1:0];
	assign {a_cs_n, a_wnr, a_en, a_mb, a_pg} =
		pins_sync_q[`DPMB_PORT_IN_W-1:`DPMB_WORD_W];
	assign b_bus = pins_sync_q[`DPMB_PORT_IN_W+`DPMB_WORD_W-1:`DPMB_PORT_IN_W];
	assign {b_cs_n, b_wnr, b_en, b_mb, b_pg} =
		pins_sync_q[2*`DPMB_PORT_IN_W-1:`DPMB_PORT_IN_W+`DPMB_WORD_W];
	assign odd_sel = pins_sync_q[`DPMB_SYNC_W-1];

	// a port drives its bus whenever it is selected for a read; the enable
	// follows the pins three edges late, so a partner turning the bus around
	// after a read must wait that long before driving it
	assign a_read_out = ~a_cs_n & ~a_wnr;
	assign b_read_out = ~b_cs_n & ~b_wnr;

	// transfers qualified by enable
	// (one transfer per edge for as long as enable stands)
	assign a_mail_wr = ~a_cs_n & a_wnr & a_en & a_mb;
	assign a_fifo_wr = ~a_cs_n & a_wnr & a_en & ~a_mb;
	assign a_mail_rd = a_read_out & a_en & a_mb;
	assign b_mail_wr = ~b_cs_n & b_wnr & b_en & b_mb;
	assign b_mail_rd = b_read_out & b_en & b_mb;
	assign b_fifo_rd = b_read_out & b_en & ~b_mb;

	// per-port trees generate mail parity only for a full mail read with generate high
	assign a_mail_gen = a_mail_rd & a_pg;
	assign b_mail_gen = b_mail_rd & b_pg;

	// ****************************************
	// data fifo from port a to port b
	// ****************************************
	wire fifo_out_valid;
	wire [`DPMB_WORD_W-1:0] fifo_out_data;
	wire fifo_pop;
	reg [`DPMB_WORD_W-1:0] fifo_word_q;

	// a read with the fifo empty is ignored
	// so the output register keeps its last word
	assign fifo_pop = b_fifo_rd & fifo_out_valid;
	assign port_b_fifo_valid = fifo_out_valid;

	// the word is stored exactly as applied
	// a write with the buffer full is dropped; the writer watches the ready port
	dpmb_fifo #(
		.WIDTH(`DPMB_WORD_W),
		.DEPTH(`DPMB_FIFO_DEPTH),
		.AW(`DPMB_FIFO_AW)
	) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(a_fifo_wr),
		.in_ready(port_a_fifo_ready),
		.in_data(a_bus),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// output register takes parity made between storage and load; generate and
	// parity sense are taken at the loading edge, so they must stand still then
	always @(posedge ref_clk) begin
		if (!resetn) begin
			fifo_word_q <= `DPMB_WORD_RST;
		end else if (fifo_pop) begin
			fifo_word_q <= b_pg ? parity_insert(fifo_out_data, odd_sel) : fifo_out_data;
		end
	end

	// ****************************************
	// mail registers and flags
	// ****************************************
	reg [`DPMB_WORD_W-1:0] mail_ab_register;
	reg [`DPMB_WORD_W-1:0] mail_ba_register;
	wire ab_load, ba_load;

	// a write lands only while the flag shows the register free
	assign ab_load = a_mail_wr & mail_ab_empty_flag;
	assign ba_load = b_mail_wr & mail_ba_empty_flag;

	// contents change only on an accepted write, never on a read
	// a discarded write leaves no trace; the writer learns of it from the flag
	always @(posedge ref_clk) begin
		if (!resetn) begin
			mail_ab_register <= `DPMB_WORD_RST;
			mail_ba_register <= `DPMB_WORD_RST;
		end else begin
			if (ab_load) begin
				mail_ab_register <= a_bus;
			end
			if (ba_load) begin
				mail_ba_register <= b_bus;
			end
		end
	end

	// flags: a load wins over a read in the same cycle
	// (a load needs the flag high already, so the read would change nothing)
	always @(posedge ref_clk) begin
		if (!resetn) begin
			mail_ab_empty_flag <= `DPMB_FLAG_RST;
			mail_ba_empty_flag <= `DPMB_FLAG_RST;
		end else begin
			if (ab_load) begin
				mail_ab_empty_flag <= 1'b0;
			end else if (b_mail_rd) begin
				mail_ab_empty_flag <= 1'b1;
			end
			if (ba_load) begin
				mail_ba_empty_flag <= 1'b0;
			end else if (a_mail_rd) begin
				mail_ba_empty_flag <= 1'b1;
			end
		end
	end

	// ****************************************
	// port outputs and parity check
	// ****************************************
	wire [`DPMB_WORD_W-1:0] a_mail_view;
	wire [`DPMB_WORD_W-1:0] b_mail_view;
	wire a_in_fail;
	wire b_in_fail;

	// generated copy of mail only goes to the pins, storage untouched
	assign a_mail_view = a_mail_gen ? parity_insert(mail_ba_register, odd_sel)
		: mail_ba_register;
	assign b_mail_view = b_mail_gen ? parity_insert(mail_ab_register, odd_sel)
		: mail_ab_register;

	// check trees on the levels each port sees at its pins
	assign a_in_fail = byte_parity_fail(a_bus, odd_sel);
	assign b_in_fail = byte_parity_fail(b_bus, odd_sel);

	// port a drive and error flag
	always @(posedge ref_clk) begin
		if (!resetn) begin
			port_a_bus_out_q <= `DPMB_WORD_RST;
			port_a_bus_oe_n_q <= `DPMB_OE_N_RST;
			port_a_parity_error_n_q <= `DPMB_PERR_N_RST;
		end else begin
			port_a_bus_out_q <= a_mail_view;
			port_a_bus_oe_n_q <= ~a_read_out;
			port_a_parity_error_n_q <= a_mail_gen ? 1'b1
				: ~a_in_fail;
		end
	end

	// port b drive and error flag
	// the fifo word and the mail view share one output register
	always @(posedge ref_clk) begin
		if (!resetn) begin
			port_b_bus_out_q <= `DPMB_WORD_RST;
			port_b_bus_oe_n_q <= `DPMB_OE_N_RST;
			port_b_parity_error_n_q <= `DPMB_PERR_N_RST;
		end else begin
			port_b_bus_out_q <= b_mb ? b_mail_view : fifo_word_q;
			port_b_bus_oe_n_q <= ~b_read_out;
			port_b_parity_error_n_q <= b_mail_gen ? 1'b1
				: ~b_in_fail;
		end
	end
endmodule
`default_nettype wire

// file: dpmb_chk.sv
// assertion checker for the dual-port mailbox top
`timescale 1ns/1ns
`default_nettype none
`include "dpmb_consts.vh"
module dpmb_chk (
	input wire logic ref_clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic port_a_select_n, // port a chip select
	input wire logic port_a_write_not_read, // port a direction
	input wire logic port_a_enable, // port a enable
	input wire logic port_a_mail_select, // port a mail select
	input wire logic port_a_parity_generate, // port a generate select
	input wire logic [`DPMB_WORD_W-1:0] port_a_bus_in, // port a bus level
	input wire logic [`DPMB_WORD_W-1:0] port_a_bus_out_q, // port a drive value
	input wire logic port_a_parity_error_n_q, // port a parity error
	input wire logic port_b_select_n, // port b chip select
	input wire logic port_b_write_not_read, // port b direction
	input wire logic port_b_enable, // port b enable
	input wire logic port_b_mail_select, // port b mail select
	input wire logic port_b_parity_generate, // port b generate select
	input wire logic [`DPMB_WORD_W-1:0] port_b_bus_in, // port b bus level
	input wire logic [`DPMB_WORD_W-1:0] port_b_bus_out_q, // port b drive value
	input wire logic port_b_parity_error_n_q, // port b parity error
	input wire logic odd_even_select, // parity sense
	input wire logic mail_ab_empty_flag, // a-to-b flag
	input wire logic mail_ba_empty_flag // b-to-a flag
);
	reg [1:0] up_q; // edges since reset release, so the pin pipeline holds real pins
	wire up = (up_q == 2'h3);
	wire wr_a = !port_a_select_n & port_a_write_not_read & port_a_enable & port_a_mail_select;
	wire rd_a = !port_a_select_n & !port_a_write_not_read & port_a_enable & port_a_mail_select;
	wire wr_b = !port_b_select_n & port_b_write_not_read & port_b_enable & port_b_mail_select;
	wire rd_b = !port_b_select_n & !port_b_write_not_read & port_b_enable & port_b_mail_select;
	wire gen_a = rd_a & port_a_parity_generate;
	wire gen_b = rd_b & port_b_parity_generate;
	// saturating count after reset
	always @(posedge ref_clk) begin
		if (!resetn) up_q <= 2'h0;
		else if (!up) up_q <= up_q + 2'h1;
	end
	// any byte failing under the selected sense
	function automatic logic bad(input logic [35:0] w, input logic odd);
		bad = 1'b0;
		for (int i = 0; i < 4; i++) bad = bad | (^w[9*i+:9] ^ odd);
	endfunction
	// every byte msb equals the parity of its low eight bits
	function automatic logic gen_ok(input logic [35:0] w, input logic odd);
		gen_ok = 1'b1;
		for (int i = 0; i < 4; i++) gen_ok = gen_ok & (w[9*i+8] == (^w[9*i+:8] ^ odd));
	endfunction
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_ab_load: assert property (up && wr_a ##2 mail_ab_empty_flag |=> !mail_ab_empty_flag)
		else $error("a-to-b flag not lowered by mail write");
	a_ba_load: assert property (up && wr_b ##2 mail_ba_empty_flag |=> !mail_ba_empty_flag)
		else $error("b-to-a flag not lowered by mail write");
	a_ab_hold: assert property (up && !rd_b ##2 !mail_ab_empty_flag |=> !mail_ab_empty_flag)
		else $error("a-to-b flag rose without a read");
	a_ab_free: assert property (up && rd_b && !wr_a |-> ##3 mail_ab_empty_flag)
		else $error("a-to-b flag not set by port b read");
	a_ba_free: assert property (up && rd_a && !wr_b |-> ##3 mail_ba_empty_flag)
		else $error("b-to-a flag not set by port a read");
	a_perr_a: assert property (up |-> ##3 port_a_parity_error_n_q ==
		($past(gen_a, 3) || !bad($past(port_a_bus_in, 3), $past(odd_even_select, 3))))
		else $error("port a parity error wrong");
	a_perr_b: assert property (up |-> ##3 port_b_parity_error_n_q ==
		($past(gen_b, 3) || !bad($past(port_b_bus_in, 3), $past(odd_even_select, 3))))
		else $error("port b parity error wrong");
	a_gen_a: assert property (up && gen_a |-> ##3 gen_ok(port_a_bus_out_q, $past(odd_even_select, 3)))
		else $error("port a generated parity wrong");
	a_gen_b: assert property (up && gen_b |-> ##3 gen_ok(port_b_bus_out_q, $past(odd_even_select, 3)))
		else $error("port b generated parity wrong");
endmodule
bind dpmb_mailbox dpmb_chk dpmb_chk_inst (.ref_clk(ref_clk), .resetn(resetn),
	.port_a_select_n(port_a_select_n), .port_a_write_not_read(port_a_write_not_read),
	.port_a_enable(port_a_enable), .port_a_mail_select(port_a_mail_select),
	.port_a_parity_generate(port_a_parity_generate), .port_a_bus_in(port_a_bus_in),
	.port_a_bus_out_q(port_a_bus_out_q), .port_a_parity_error_n_q(port_a_parity_error_n_q),
	.port_b_select_n(port_b_select_n), .port_b_write_not_read(port_b_write_not_read),
	.port_b_enable(port_b_enable), .port_b_mail_select(port_b_mail_select),
	.port_b_parity_generate(port_b_parity_generate), .port_b_bus_in(port_b_bus_in),
	.port_b_bus_out_q(port_b_bus_out_q), .port_b_parity_error_n_q(port_b_parity_error_n_q),
	.odd_even_select(odd_even_select), .mail_ab_empty_flag(mail_ab_empty_flag),
	.mail_ba_empty_flag(mail_ba_empty_flag));
`default_nettype wire

// file: dpmb_agent.sv
// far-side processor bus model: resolves one shared data bus
`timescale 1ns/1ns
`default_nettype none
module dpmb_agent (
	input wire logic ref_clk, // system clock
	input wire logic oe_n, // block drives while low
	input wire logic [35:0] dout, // block drive value
	input wire logic ext_en, // processor drives while high
	input wire logic [35:0] ext_val, // processor drive value
	output logic [35:0] level // resolved bus level
);
	reg [35:0] last_q; // level seen at the last edge
	// remember the bus so a floating bus can be shown as changing
	always @(posedge ref_clk) begin
		last_q <= level;
	end
	// undriven bus toggles each cycle so no stale value passes for data
	always_comb begin
		if (!oe_n) level = dout;
		else if (ext_en) level = ext_val;
		else level = ~last_q;
	end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking testbench for the dual-port mailbox
`timescale 1ns/1ns
`default_nettype none
`include "dpmb_consts.vh"
module tb;
	logic ref_clk, resetn, odd;
	logic [4:0] ctl [2]; // select_n, write_not_read, enable, mail, generate
	logic [35:0] ext [2], base, d1;
	logic [35:0] lvl_a, lvl_b, out_a, out_b;
	wire logic oe_a, oe_b, pe_a, pe_b, rdy, vld, f_ab, f_ba;
	int n_fail = 0;
	int compares = 0;
	dpmb_mailbox dpmb_mailbox_inst (.ref_clk(ref_clk), .resetn(resetn),
		.port_a_select_n(ctl[0][4]), .port_a_write_not_read(ctl[0][3]),
		.port_a_enable(ctl[0][2]), .port_a_mail_select(ctl[0][1]),
		.port_a_parity_generate(ctl[0][0]), .port_a_bus_in(lvl_a), .port_a_bus_out_q(out_a),
		.port_a_bus_oe_n_q(oe_a), .port_a_parity_error_n_q(pe_a), .port_a_fifo_ready(rdy),
		.port_b_select_n(ctl[1][4]), .port_b_write_not_read(ctl[1][3]),
		.port_b_enable(ctl[1][2]), .port_b_mail_select(ctl[1][1]),
		.port_b_parity_generate(ctl[1][0]), .port_b_bus_in(lvl_b), .port_b_bus_out_q(out_b),
		.port_b_bus_oe_n_q(oe_b), .port_b_parity_error_n_q(pe_b), .port_b_fifo_valid(vld),
		.odd_even_select(odd), .mail_ab_empty_flag(f_ab), .mail_ba_empty_flag(f_ba));
	dpmb_agent agent_a (.ref_clk(ref_clk), .oe_n(oe_a), .dout(out_a),
		.ext_en(ctl[0][4] | ctl[0][3]), .ext_val(ext[0]), .level(lvl_a));
	dpmb_agent agent_b (.ref_clk(ref_clk), .oe_n(oe_b), .dout(out_b),
		.ext_en(ctl[1][4] | ctl[1][3]), .ext_val(ext[1]), .level(lvl_b));
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	function automatic logic [35:0] gen(input logic [35:0] w, input logic o);
		gen = w;
		for (int i = 0; i < 4; i++) gen[9*i+8] = ^w[9*i+:8] ^ o;
	endfunction
	function automatic logic perr(input logic [35:0] w, input logic o);
		perr = 1'b1;
		for (int i = 0; i < 4; i++) if (^w[9*i+:9] ^ o) perr = 1'b0;
	endfunction
	// one mail write, then the pin pipeline settles and the error flag is judged
	task automatic mwr(input bit p, input logic [35:0] d);
		ctl[p] = 5'h0E;
		ext[p] = d;
		cyc(1);
		ctl[p] = 5'h10;
		cyc(2);
		chk(p ? pe_b : pe_a, perr(d, odd));
	endtask
	// mail read held until the answer shows on the bus, then idle until the
	// block lets the bus go, so the next write does not meet its drive
	task automatic mrd(input bit p, input logic pg, input logic [35:0] exp);
		ctl[p] = 5'h06 | pg;
		cyc(3);
		chk(p ? lvl_b : lvl_a, exp);
		chk(p ? oe_b : oe_a, 36'h0);
		if (pg) chk(p ? pe_b : pe_a, 36'h1);
		ctl[p] = 5'h10;
		cyc(3);
		chk(p ? oe_b : oe_a, 36'h1);
	endtask
	task automatic end_sim;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog and sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		end_sim;
	end
	initial begin
		resetn = 1'b0;
		odd = 1'b0;
		ctl[0] = 5'h10;
		ctl[1] = 5'h10;
		ext[0] = 36'h0;
		ext[1] = 36'h0;
		cyc(4);
		chk({f_ab, f_ba, oe_a, oe_b, pe_a, pe_b, vld, rdy}, 36'hFD);
		resetn = 1'b1;
		cyc(1);
		for (int o = 0; o < 2; o++) begin
			odd = o[0];
			base = 36'h1A5C30F1E ^ o;
			d1 = gen(base, odd) ^ 36'h100;
			mwr(0, d1);
			chk(f_ab, 36'h0);
			mwr(0, gen(base, odd));
			mrd(1, 1'b0, d1);
			chk(f_ab, 36'h1);
			mrd(1, 1'b1, gen(d1, odd));
			mrd(1, 1'b0, d1);
			mwr(1, ~d1);
			chk(f_ba, 36'h0);
			mrd(0, 1'b1, gen(~d1, odd));
			chk(f_ba, 36'h1);
			mrd(0, 1'b0, ~d1);
		end
		// fill the buffer past its depth; the surplus word is refused
		ctl[0] = 5'h0C;
		for (int i = 0; i <= 16; i++) begin
			ext[0] = 36'h5A5C30F10 + 36'(i);
			cyc(1);
		end
		ctl[0] = 5'h10;
		cyc(3);
		chk(rdy, 36'h0);
		// drain with stalls; generate held steady around each load
		for (int i = 0; i < 16; i++) begin
			ctl[1] = 5'h04 | i[0];
			cyc(1);
			ctl[1] = 5'h00 | i[0];
			cyc(3);
			base = 36'h5A5C30F10 + 36'(i);
			chk(lvl_b, i[0] ? gen(base, odd) : base);
			ctl[1] = 5'h10;
			cyc(1);
		end
		chk({vld, rdy}, 36'h1);
		end_sim;
	end
endmodule
`default_nettype wire
